// *** pkg/nmc_pkg.sv ***
// Package for the network master configuration register bank.
// Assumes a 16-bit holding register port addressed by register number.
package nmc_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_STATUS      = 16'h9d3e;
  localparam logic [15:0] ADDR_ROLE_SWAP   = 16'h9d3f;
  localparam logic [15:0] ADDR_SCAN_FIRST  = 16'ha556;
  localparam logic [15:0] ADDR_TYPE_FIRST  = 16'ha650;
  localparam logic [15:0] ADDR_DEV_COUNT   = 16'ha74e;
  localparam logic [15:0] ADDR_FIELD_BAUD  = 16'ha74f;
  localparam logic [15:0] ADDR_RX_TIMEOUT  = 16'ha750;
  localparam logic [15:0] ADDR_EXC_REPORT  = 16'ha751;
  localparam logic [15:0] ADDR_PORT_MODE   = 16'ha74c;
  localparam logic [15:0] ADDR_HOST_CFG    = 16'ha74d;
  localparam logic [15:0] ADDR_HOST_SLAVE  = 16'ha752;
  localparam logic [15:0] ADDR_HOST_BAUD   = 16'ha753;
  localparam logic [15:0] ADDR_HOST_PARITY = 16'ha754;
  localparam logic [15:0] ADDR_DIAG_MODE   = 16'ha755;
  localparam logic [15:0] ADDR_SW_VERSION  = 16'ha756;

  // ----------------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------------
  localparam int STAT_PRIMARY_BIT   = 8;
  localparam int STAT_SECONDARY_BIT = 9;
  localparam int STAT_STBY_PRI_BIT  = 4;
  localparam int STAT_STBY_SEC_BIT  = 5;
  localparam logic [15:0] BAUD_DEFAULT   = 16'h2580;
  localparam logic [15:0] RX_TIMEOUT_DEF = 16'h0032;
  localparam logic [15:0] EXC_REPORT_DEF = 16'h0001;
  localparam logic [15:0] DEV_COUNT_DEF  = 16'h00fa;
  localparam logic [15:0] TYPE_DEFAULT   = 16'h0002;
  localparam logic [15:0] SLAVE_DEF      = 16'h0001;
  localparam logic [15:0] PARITY_DEF     = 16'h0000;
  localparam logic [15:0] ZERO16         = 16'h0000;
  localparam logic [7:0]  LIST_LEN       = 8'hfa;
  localparam int          INIT_PULSE_CYC = 4;
  localparam logic [11:0] SW_VERSION_DEF = 12'h123;  // Arbitrary value.

  // ----------------------------------------------------------------------
  // Enumerations and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    NMC_PORT_RS232     = 2'h0,
    NMC_PORT_RS485_4W  = 2'h1,
    NMC_PORT_RS485_2W  = 2'h2
  } nmc_port_mode_t;

  typedef enum logic [1:0] {
    NMC_SWAP_IDLE,
    NMC_SWAP_REQ,
    NMC_SWAP_WAIT
  } nmc_swap_state_t;

  // Data set that the poller fetches for one address.
  typedef struct packed {
    logic valve_status;
    logic pos_percent;
    logic pos_12bit;
    logic setpoint;
    logic analog_out;
    logic torque;
    logic user_ain1;
    logic user_ain2;
    logic coils_inputs;
  } nmc_acq_set_t;

  // Host port settings.
  typedef struct packed {
    nmc_port_mode_t mode;
    logic [7:0]     slave_addr;
    logic [15:0]    baud;
    logic [1:0]     parity;
  } nmc_host_cfg_t;

  // Field network settings.
  typedef struct packed {
    logic [7:0]  dev_count;
    logic [15:0] baud;
    logic [15:0] rx_timeout_ms;
    logic        exc_report_en;
  } nmc_field_cfg_t;

endpackage

// *** hdl/nmc_regs.sv ***
// Configuration and status register bank of a redundant network master.
// Assumes a single-cycle holding register port from the host side logic
// and role information from the chassis redundancy logic.
//
// Overview of operation
// - Status bit 8 set when this chassis is the primary master.
// - Status bit 9 set when this chassis is the secondary master.
// - Status bits 4 and 5 show which chassis is the hot standby.
// - Non-zero write to swap register swaps roles, then reads zero.
// - Software version is three digits, point after the top digit.
// - Coprocessor software access blocked unless diagnostic mode is set.
// - Port mode selects RS232, or RS422/RS485 4-wire or 2-wire.
// - Host slave address, baud and parity each come from a register.
// - Six contiguous registers configure the field network and master.
// - Polled actuator count comes from the device count register.
// - Invalid field baud value falls back to 9600 baud.
// - All devices and ports default to 9600 baud.
// - Receiver time-out sets reply wait, default 50 ms.
// - Zero disables exception reporting, non-zero enables; enabled default.
// - Scan list of 250 entries, defaults reload as 1 through 250.
// - Default scan order runs address 1 at ring port A onward.
// - Type list one code per address, defaults reload to type 2.
// - Every type acquires valve status inputs 16 to 31.
// - Types 0,1 percent position; 2,3 12-bit set; 1,3 add coils.
// - Types 4,5 add torque and two user inputs; 5 adds coils.
// - Type 7 position, setpoint, torque, one input; 8 drops input.
// - Config change pulses a module reinitialise with new values.
// - Config writes are mirrored to the partner chassis.
`timescale 1ns/1ps

module nmc_regs
  import nmc_pkg::*;
#(
  parameter int LIST_DEPTH = 250
) (
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  input  wire logic           clk_en,
  // Holding register port.
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  input  wire logic [15:0]    reg_addr,
  input  wire logic [15:0]    reg_wdata,
  output logic      [15:0]    reg_rdata,
  output logic                reg_ack,
  output logic                reg_err,
  // Chassis role and redundancy link.
  input  wire logic           chassis_is_primary,
  input  wire logic           local_is_standby,
  output logic                swap_req,
  input  wire logic           swap_done,
  output logic                mirror_wr,
  output logic      [15:0]    mirror_addr,
  output logic      [15:0]    mirror_data,
  input  wire logic           peer_wr,
  input  wire logic [15:0]    peer_addr,
  input  wire logic [15:0]    peer_data,
  input  wire logic           reload_defaults,
  // Settings to the host port, the poller and the coprocessor.
  output nmc_host_cfg_t       host_cfg,
  output nmc_field_cfg_t      field_cfg,
  output logic                coproc_access_en,
  output logic                host_reinit,
  output logic                field_reinit,
  input  wire logic [7:0]     poll_addr,
  output logic      [7:0]     poll_next_addr,
  output nmc_acq_set_t        poll_acq
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0]  scan_list [LIST_DEPTH];
  logic [3:0]  type_list [LIST_DEPTH];
  logic [15:0] role_swap_command;
  logic [15:0] port_mode_reg;
  logic [15:0] host_slave_reg;
  logic [15:0] host_baud_reg;
  logic [15:0] host_parity_reg;
  logic [15:0] field_device_count;
  logic [15:0] field_baud_rate;
  logic [15:0] receiver_timeout;
  logic [15:0] exception_report_enable;
  logic        diag_mode;
  logic        role_primary;
  nmc_swap_state_t swap_state;
  logic [2:0]  host_init_cnt;
  logic [2:0]  field_init_cnt;

  // A write from either the local host port or the partner chassis.
  logic        wr_any;
  logic [15:0] wr_addr;
  logic [15:0] wr_data;
  logic        loc_wr;

  assign loc_wr  = clk_en && reg_wr;
  assign wr_any  = loc_wr || (clk_en && peer_wr);
  assign wr_addr = loc_wr ? reg_addr  : peer_addr;
  assign wr_data = loc_wr ? reg_wdata : peer_data;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Returns true when the field baud value is a supported rate.
  function automatic logic baud_valid(input logic [15:0] b);
    baud_valid = (b == 16'h04b0) || (b == 16'h0960) || (b == 16'h12c0) ||
                 (b == 16'h2580) || (b == 16'h4b00) || (b == 16'h9600);
  endfunction

  // Returns true when an address falls inside a list window.
  function automatic logic in_list(input logic [15:0] a,
                                   input logic [15:0] base);
    in_list = (a >= base) && (a < base + 16'(LIST_DEPTH));
  endfunction

  // Maps a device type code to its acquisition set.
  function automatic nmc_acq_set_t type_to_acq(input logic [3:0] t);
    nmc_acq_set_t s;
    s = '0;
    s.valve_status = 1'b1;
    case (t)
      4'h0, 4'h1: begin
        s.pos_percent  = 1'b1;
        s.coils_inputs = (t == 4'h1);
      end
      4'h3: begin
        s.pos_12bit    = 1'b1;
        s.setpoint     = 1'b1;
        s.analog_out   = 1'b1;
        s.coils_inputs = 1'b1;
      end
      4'h4, 4'h5: begin
        s.pos_12bit    = 1'b1;
        s.setpoint     = 1'b1;
        s.analog_out   = 1'b1;
        s.torque       = 1'b1;
        s.user_ain1    = 1'b1;
        s.user_ain2    = 1'b1;
        s.coils_inputs = (t == 4'h5);
      end
      4'h7, 4'h8: begin
        s.pos_12bit    = 1'b1;
        s.setpoint     = 1'b1;
        s.torque       = 1'b1;
        s.user_ain1    = (t == 4'h7);
      end
      default: begin
        s.pos_12bit    = 1'b1;
        s.setpoint     = 1'b1;
        s.analog_out   = 1'b1;
      end
    endcase
    type_to_acq = s;
  endfunction

  // ----------------------------------------------------------------------
  // Host port configuration
  // ----------------------------------------------------------------------
  // Port mode, slave address, baud and parity each from their own word.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (clk_en && reload_defaults)) begin
      port_mode_reg   <= ZERO16;
      host_slave_reg  <= SLAVE_DEF;
      host_baud_reg   <= BAUD_DEFAULT;
      host_parity_reg <= PARITY_DEF;
    end else if (wr_any) begin
      if (wr_addr == ADDR_PORT_MODE) begin
        port_mode_reg <= wr_data;
      end else if (wr_addr == ADDR_HOST_SLAVE) begin
        host_slave_reg <= wr_data;
      end else if (wr_addr == ADDR_HOST_BAUD) begin
        host_baud_reg <= wr_data;
      end else if (wr_addr == ADDR_HOST_PARITY) begin
        host_parity_reg <= wr_data;
      end
    end
  end

  // Unknown mode codes fall back to RS232.
  always_comb begin
    case (port_mode_reg[1:0])
      2'h1:    host_cfg.mode = NMC_PORT_RS485_4W;
      2'h2:    host_cfg.mode = NMC_PORT_RS485_2W;
      default: host_cfg.mode = NMC_PORT_RS232;
    endcase
    host_cfg.slave_addr = host_slave_reg[7:0];
    host_cfg.baud       = host_baud_reg;
    host_cfg.parity     = host_parity_reg[1:0];
  end

  // ----------------------------------------------------------------------
  // Field network configuration block
  // ----------------------------------------------------------------------
  // The contiguous block from device count through exception reporting.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (clk_en && reload_defaults)) begin
      field_device_count      <= DEV_COUNT_DEF;
      field_baud_rate         <= BAUD_DEFAULT;
      receiver_timeout        <= RX_TIMEOUT_DEF;
      exception_report_enable <= EXC_REPORT_DEF;
    end else if (wr_any) begin
      if (wr_addr == ADDR_DEV_COUNT) begin
        field_device_count <= wr_data;
      end else if (wr_addr == ADDR_FIELD_BAUD) begin
        field_baud_rate <= wr_data;
      end else if (wr_addr == ADDR_RX_TIMEOUT) begin
        receiver_timeout <= wr_data;
      end else if (wr_addr == ADDR_EXC_REPORT) begin
        exception_report_enable <= wr_data;
      end
    end
  end

  // Field settings as seen by the poller.
  always_comb begin
    field_cfg.dev_count     = (field_device_count > 16'(LIST_DEPTH)) ?
                              8'(LIST_DEPTH) : field_device_count[7:0];
    field_cfg.baud          = baud_valid(field_baud_rate) ?
                              field_baud_rate : BAUD_DEFAULT;
    field_cfg.rx_timeout_ms = receiver_timeout;
    field_cfg.exc_report_en = (exception_report_enable != ZERO16);
  end

  // ----------------------------------------------------------------------
  // Scan order and device type lists
  // ----------------------------------------------------------------------
  // Each entry reloads to its own address for scan, type 2 for types.
  for (genvar i = 0; i < LIST_DEPTH; i++) begin : g_list
    always_ff @(posedge ref_clk) begin
      if (!rst_n || (clk_en && reload_defaults)) begin
        scan_list[i] <= 8'(i + 1);
        type_list[i] <= TYPE_DEFAULT[3:0];
      end else if (wr_any) begin
        if (wr_addr == ADDR_SCAN_FIRST + 16'(i)) begin
          scan_list[i] <= wr_data[7:0];
        end else if (wr_addr == ADDR_TYPE_FIRST + 16'(i)) begin
          type_list[i] <= wr_data[3:0];
        end
      end
    end
  end

  // Poller lookup: next address in ring order and its data set.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      poll_next_addr <= 8'h01;
      poll_acq       <= '0;
    end else if (clk_en) begin
      if (poll_addr < 8'(LIST_DEPTH)) begin
        poll_next_addr <= scan_list[poll_addr];
        poll_acq       <= type_to_acq(type_list[poll_addr]);
      end else begin
        poll_next_addr <= scan_list[0];
        poll_acq       <= type_to_acq(TYPE_DEFAULT[3:0]);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Diagnostic mode gate
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      diag_mode <= 1'b0;
    end else if (wr_any && wr_addr == ADDR_DIAG_MODE) begin
      diag_mode <= (wr_data != ZERO16);
    end
  end

  assign coproc_access_en = diag_mode;

  // ----------------------------------------------------------------------
  // Role swap sequencer
  // ----------------------------------------------------------------------
  // Holds the command word until the partner reports the swap finished.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      swap_state        <= NMC_SWAP_IDLE;
      role_swap_command <= ZERO16;
      swap_req          <= 1'b0;
    end else if (clk_en) begin
      case (swap_state)
        NMC_SWAP_IDLE: begin
          if (wr_any && wr_addr == ADDR_ROLE_SWAP && wr_data != ZERO16) begin
            role_swap_command <= wr_data;
            swap_state        <= NMC_SWAP_REQ;
          end
        end
        NMC_SWAP_REQ: begin
          swap_req   <= 1'b1;
          swap_state <= NMC_SWAP_WAIT;
        end
        NMC_SWAP_WAIT: begin
          if (swap_done) begin
            swap_req          <= 1'b0;
            role_swap_command <= ZERO16;
            swap_state        <= NMC_SWAP_IDLE;
          end
        end
        default: swap_state <= NMC_SWAP_IDLE;
      endcase
    end
  end

  // Chassis role sampled after reset release, not under reset.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      role_primary <= 1'b0;
    end else if (clk_en) begin
      role_primary <= chassis_is_primary;
    end
  end

  // ----------------------------------------------------------------------
  // Reinitialise pulses and mirroring
  // ----------------------------------------------------------------------
  // A config write restarts the owning module for a few cycles.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      host_init_cnt  <= '0;
      field_init_cnt <= '0;
    end else if (clk_en) begin
      if (wr_any && wr_addr >= ADDR_PORT_MODE &&
          wr_addr <= ADDR_HOST_CFG) begin
        host_init_cnt <= 3'(INIT_PULSE_CYC);
      end else if (wr_any && (wr_addr == ADDR_HOST_SLAVE ||
                   wr_addr == ADDR_HOST_BAUD || wr_addr == ADDR_HOST_PARITY))
      begin
        host_init_cnt <= 3'(INIT_PULSE_CYC);
      end else if (host_init_cnt != 3'h0) begin
        host_init_cnt <= host_init_cnt - 3'h1;
      end
      if (wr_any && (wr_addr == ADDR_DEV_COUNT ||
          wr_addr == ADDR_FIELD_BAUD || wr_addr == ADDR_RX_TIMEOUT ||
          wr_addr == ADDR_EXC_REPORT ||
          in_list(wr_addr, ADDR_SCAN_FIRST) ||
          in_list(wr_addr, ADDR_TYPE_FIRST))) begin
        field_init_cnt <= 3'(INIT_PULSE_CYC);
      end else if (field_init_cnt != 3'h0) begin
        field_init_cnt <= field_init_cnt - 3'h1;
      end
    end
  end

  assign host_reinit  = (host_init_cnt != 3'h0);
  assign field_reinit = (field_init_cnt != 3'h0);

  // Local writes other than to status and software version go to the partner chassis one cycle later.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mirror_wr   <= 1'b0;
      mirror_addr <= ZERO16;
      mirror_data <= ZERO16;
    end else if (clk_en) begin
      mirror_wr <= reg_wr && reg_addr != ADDR_STATUS &&
                   reg_addr != ADDR_SW_VERSION;
      if (reg_wr) begin
        mirror_addr <= reg_addr;
        mirror_data <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Registered read data; unmapped addresses answer an error and zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= ZERO16;
      reg_ack   <= 1'b0;
      reg_err   <= 1'b0;
    end else if (clk_en) begin
      reg_ack   <= reg_rd || reg_wr;
      reg_err   <= 1'b0;
      reg_rdata <= ZERO16;
      if (reg_rd) begin
        if (reg_addr == ADDR_STATUS) begin
          reg_rdata[STAT_PRIMARY_BIT]   <= role_primary;
          reg_rdata[STAT_SECONDARY_BIT] <= !role_primary;
          reg_rdata[STAT_STBY_PRI_BIT]  <= local_is_standby ==
                                           role_primary;
          reg_rdata[STAT_STBY_SEC_BIT]  <= local_is_standby !=
                                           role_primary;
        end else if (reg_addr == ADDR_ROLE_SWAP) begin
          reg_rdata <= role_swap_command;
        end else if (reg_addr == ADDR_SW_VERSION) begin
          reg_rdata <= {4'h0, SW_VERSION_DEF};
        end else if (reg_addr == ADDR_PORT_MODE) begin
          reg_rdata <= port_mode_reg;
        end else if (reg_addr == ADDR_HOST_CFG) begin
          reg_rdata <= {14'h0000, diag_mode, host_reinit};
        end else if (reg_addr == ADDR_HOST_SLAVE) begin
          reg_rdata <= host_slave_reg;
        end else if (reg_addr == ADDR_HOST_BAUD) begin
          reg_rdata <= host_baud_reg;
        end else if (reg_addr == ADDR_HOST_PARITY) begin
          reg_rdata <= host_parity_reg;
        end else if (reg_addr == ADDR_DIAG_MODE) begin
          reg_rdata <= {15'h0000, diag_mode};
        end else if (reg_addr == ADDR_DEV_COUNT) begin
          reg_rdata <= field_device_count;
        end else if (reg_addr == ADDR_FIELD_BAUD) begin
          reg_rdata <= field_baud_rate;
        end else if (reg_addr == ADDR_RX_TIMEOUT) begin
          reg_rdata <= receiver_timeout;
        end else if (reg_addr == ADDR_EXC_REPORT) begin
          reg_rdata <= exception_report_enable;
        end else if (in_list(reg_addr, ADDR_SCAN_FIRST)) begin
          reg_rdata <= {8'h00, scan_list[8'(reg_addr - ADDR_SCAN_FIRST)]};
        end else if (in_list(reg_addr, ADDR_TYPE_FIRST)) begin
          reg_rdata <= {12'h000, type_list[8'(reg_addr - ADDR_TYPE_FIRST)]};
        end else begin
          reg_err <= 1'b1;
        end
      end
    end
  end

endmodule

// *** test/nmc_props.sv ***
// Checker for the register bank, watching only its ports.
// Assumes the bench holds clk_en high throughout.
`timescale 1ns/1ps
module nmc_props
  import nmc_pkg::*;
(
  input wire logic           ref_clk,
  input wire logic           rst_n,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [15:0]    reg_addr,
  input wire logic [15:0]    reg_wdata,
  input wire logic [15:0]    reg_rdata,
  input wire logic           reg_err,
  input wire logic           chassis_is_primary,
  input wire logic           swap_req,
  input wire logic           swap_done,
  input wire logic           mirror_wr,
  input wire logic [15:0]    mirror_addr,
  input wire logic [15:0]    mirror_data,
  input wire nmc_field_cfg_t field_cfg,
  input wire logic           field_reinit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  stat_primary_a: assert property (
    reg_rd && reg_addr == ADDR_STATUS
    |=> reg_rdata[8] == $past(chassis_is_primary, 2)) else $error("bit 8");
  stat_secondary_a: assert property (
    reg_rd && reg_addr == ADDR_STATUS
    |=> reg_rdata[9] != $past(chassis_is_primary, 2)) else $error("bit 9");
  swap_start_a: assert property (
    reg_wr && reg_addr == ADDR_ROLE_SWAP && reg_wdata != 16'h0 && !swap_req
    |-> ##2 swap_req) else $error("swap not started");
  swap_end_a: assert property (
    swap_req && swap_done |=> !swap_req) else $error("swap not ended");
  mirror_copy_a: assert property (
    reg_wr && reg_addr == ADDR_RX_TIMEOUT |=> mirror_wr
    && mirror_addr == $past(reg_addr)
    && mirror_data == $past(reg_wdata)) else $error("no mirror");
  baud_valid_a: assert property (
    field_cfg.baud inside {16'h04b0, 16'h0960, 16'h12c0, 16'h2580,
    16'h4b00, 16'h9600}) else $error("bad baud");
  exc_enable_a: assert property (
    reg_wr && reg_addr == ADDR_EXC_REPORT |=> field_cfg.exc_report_en
    == ($past(reg_wdata) != 16'h0)) else $error("exception flag");
  field_reinit_a: assert property (
    reg_wr && reg_addr == ADDR_RX_TIMEOUT |-> ##[1:2] field_reinit)
    else $error("no reinit");
  cover property (swap_req && swap_done);
  cover property (reg_err);
  cover property (field_reinit);
endmodule
bind nmc_regs nmc_props props_u (.*);

// *** test/nmc_peer_model.sv ***
// Peer chassis model that answers role swap requests.
// Assumes the clock of the register bank; delay sets the answer time.
`timescale 1ns/1ps
module nmc_peer_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] delay,
  input  wire logic       swap_req,
  output logic            swap_done,
  output logic            standby
);
  logic [3:0] cnt;
  // Waits out the delay, pulses done once and swaps the roles.
  always_ff @(posedge ref_clk) begin
    swap_done <= 1'b0;
    cnt <= 4'h0;
    if (!rst_n) begin
      standby <= 1'b0;
    end else if (swap_req && !swap_done) begin
      cnt <= cnt + 4'h1;
      if (cnt == delay) begin
        swap_done <= 1'b1;
        cnt <= 4'h0;
        standby <= ~standby;
      end
    end
  end
endmodule

// *** test/network_master_config_regs_tb.sv ***
// Self-checking bench for the register bank with random stimulus.
// Assumes the package, checker and peer model are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h got %h", n, e, a); end end
module network_master_config_regs_tb;
  import nmc_pkg::*;
  logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rld = 0;
  logic chassis_is_primary = 1, peer_wr = 0;
  logic [15:0] reg_addr = 0, reg_wdata = 0, peer_addr = 0, peer_data = 0;
  logic [15:0] reg_rdata, d;
  logic [7:0] poll_addr = 0, poll_next_addr;
  logic [3:0] dly = 0;
  logic swap_req, swap_done, local_is_standby, coproc;
  logic [15:0] vb [6] = '{16'h04b0, 16'h0960, 16'h12c0, 16'h2580,
                          16'h4b00, 16'h9600};
  nmc_host_cfg_t host_cfg;
  nmc_field_cfg_t field_cfg;
  nmc_acq_set_t poll_acq;
  int miscompares = 0, total_checks = 0, seed = 90793, i, r;
  nmc_regs dut_u (.ref_clk, .rst_n, .clk_en(1'b1), .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_ack(), .reg_err(),
    .chassis_is_primary, .local_is_standby, .swap_req, .swap_done,
    .mirror_wr(), .mirror_addr(), .mirror_data(), .peer_wr, .peer_addr,
    .peer_data, .reload_defaults(rld), .host_cfg, .field_cfg,
    .coproc_access_en(coproc), .host_reinit(), .field_reinit(),
    .poll_addr, .poll_next_addr, .poll_acq);
  nmc_peer_model peer_u (.ref_clk, .rst_n, .delay(dly), .swap_req,
    .swap_done, .standby(local_is_standby));
  // Free-running reference clock.
  initial forever #25 ref_clk = ~ref_clk;
  function automatic logic [15:0] exp_baud(input logic [15:0] v);
    return (v inside {vb}) ? v : 16'h2580;
  endfunction
  // Data set that each device type code is expected to fetch.
  function automatic nmc_acq_set_t exp_acq(input int t);
    nmc_acq_set_t s;
    s = '0;
    s.valve_status = 1'b1;
    s.pos_percent  = (t < 2);
    s.pos_12bit    = (t > 1);
    s.setpoint     = (t > 1);
    s.analog_out   = (t > 1) && !(t inside {7, 8});
    s.torque       = t inside {4, 5, 7, 8};
    s.user_ain1    = t inside {4, 5, 7};
    s.user_ain2    = t inside {4, 5};
    s.coils_inputs = t inside {1, 3, 5};
    return s;
  endfunction
  task automatic wr(input logic [15:0] a, v);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk) reg_wr <= 0;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, e, m, input string n);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge ref_clk) reg_rd <= 0;
    #1 `CHK(n, e, reg_rdata & m)
    @(posedge ref_clk);
  endtask
  task automatic wait_swap(input logic v);
    for (r = 0; r < 50 && swap_req !== v; r++) @(posedge ref_clk) #1;
    if (r == 50) stop_test(1);
  endtask
  task automatic stop_test(input bit hung);
    if (hung) miscompares++;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence: defaults, status, swap, random settings, types, reload.
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    rd(ADDR_FIELD_BAUD, 16'h2580, 16'hffff, "baud");
    rd(ADDR_RX_TIMEOUT, 16'h0032, 16'hffff, "rxto");
    rd(ADDR_EXC_REPORT, 16'h0001, 16'hffff, "exc");
    rd(ADDR_SCAN_FIRST, 16'h0001, 16'hffff, "scan");
    rd(ADDR_SW_VERSION, 16'h0123, 16'hffff, "ver");
    rd(16'h0000, 16'h0000, 16'hffff, "unmapped");
    `CHK("next", 8'h01, poll_next_addr)
    `CHK("coproc", 1'b0, coproc)
    `CHK("hbaud", 16'h2580, host_cfg.baud)
    wr(ADDR_DIAG_MODE, 16'h0001);
    `CHK("diag", 1'b1, coproc)
    for (i = 0; i < 2; i++) begin
      chassis_is_primary <= i[0];
      @(posedge ref_clk);
      rd(ADDR_STATUS, {6'h0, ~i[0], i[0], 2'h0, local_is_standby != i[0],
         local_is_standby == i[0], 4'h0}, 16'h0330, "stat");
      dly <= 4'(i * 7);
      wr(ADDR_ROLE_SWAP, 16'h0005);
      wait_swap(1);
      wait_swap(0);
      rd(ADDR_ROLE_SWAP, 16'h0, 16'hffff, "swap");
    end
    for (i = 0; i < 24; i++) begin
      r = $random(seed);
      d = (i < 6) ? vb[i] : r[15:0];
      wr(ADDR_FIELD_BAUD, d);
      `CHK("fbaud", exp_baud(d), field_cfg.baud)
      wr(ADDR_EXC_REPORT, (i % 3 == 0) ? 16'h0 : d);
      `CHK("exc_en", i % 3 != 0 && d != 0, field_cfg.exc_report_en)
      wr(ADDR_DEV_COUNT, {8'h0, d[7:0]});
      `CHK("count", d[7:0] > 250 ? 8'hfa : d[7:0], field_cfg.dev_count)
      wr(ADDR_HOST_SLAVE, {8'h0, d[15:8]});
      `CHK("slave", d[15:8], host_cfg.slave_addr)
      wr(ADDR_HOST_PARITY, {14'h0, d[1:0]});
      `CHK("parity", d[1:0], host_cfg.parity)
      wr(ADDR_PORT_MODE, 16'(i % 4));
      `CHK("mode", 2'(i % 4 == 3 ? 0 : i % 4), host_cfg.mode)
    end
    for (i = 0; i < 10; i++) begin
      wr(ADDR_TYPE_FIRST, 16'(i));
      repeat (2) @(posedge ref_clk);
      #1 `CHK("vstat", 1'b1, poll_acq.valve_status)
      `CHK("coils", i inside {1, 3, 5}, poll_acq.coils_inputs)
      `CHK("setp", !(i inside {0, 1}), poll_acq.setpoint)
      `CHK("torque", i inside {4, 5, 7, 8}, poll_acq.torque)
      `CHK("ain2", i inside {4, 5}, poll_acq.user_ain2)
      `CHK("acq", exp_acq(i), poll_acq)
    end
    wr(ADDR_RX_TIMEOUT, 16'h000a);
    peer_wr <= 1;
    peer_addr <= ADDR_RX_TIMEOUT;
    peer_data <= 16'h0064;
    @(posedge ref_clk) peer_wr <= 0;
    rd(ADDR_RX_TIMEOUT, 16'h0064, 16'hffff, "peer");
    `CHK("rx_ms", 16'h0064, field_cfg.rx_timeout_ms)
    rld <= 1;
    @(posedge ref_clk) rld <= 0;
    rd(ADDR_FIELD_BAUD, 16'h2580, 16'hffff, "reload");
    rd(ADDR_TYPE_FIRST, 16'h0002, 16'hffff, "rtype");
    stop_test(0);
  end
endmodule
